//--- test/char_lcd_instruction_decoder_tb.sv
// self-checking bench for the lcd instruction decoder
`timescale 1ns/10ps

module char_lcd_instruction_decoder_tb;
   logic clk_sys = 1'b0; // 10 mhz system clock
   logic reset = 1'b1; // held for eight cycles
   logic bus_enable;
   logic reg_select_line;
   logic read_write;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic data_oe;
   logic busy_flag;
   logic bus_width_bit;
   logic two_line;
   logic font_5x11;
   logic glyph_selected;
   logic [6:0] address_counter;
   logic [6:0] display_offset;
   logic entry_increment;
   logic shift_on_write_bit;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] q;

   always #50 clk_sys = ~clk_sys;

   cid_decoder dut (.clk_sys(clk_sys), .reset(reset),
      .bus_enable(bus_enable), .reg_select_line(reg_select_line),
      .read_write(read_write), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .busy_flag(busy_flag),
      .bus_width_bit(bus_width_bit), .two_line(two_line),
      .font_5x11(font_5x11), .glyph_selected(glyph_selected),
      .address_counter(address_counter), .display_offset(display_offset),
      .entry_increment(entry_increment),
      .shift_on_write_bit(shift_on_write_bit));

   cid_host_model host (.clk_sys(clk_sys), .data_out(data_out),
      .bus_enable(bus_enable), .reg_select_line(reg_select_line),
      .read_write(read_write), .data_in(data_in));

   // compare one value; four-state equality so unknowns fail
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic ac_is(input logic [6:0] exp);
      chk({1'b0, address_counter}, {1'b0, exp});
   endtask

   task automatic test_end(input string name);
      $display("test %s done, mismatches so far %0d", name, n_mismatch);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= 60000) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t timeout", $time);
         test_done();
      end
   end

   initial begin
      repeat (8) @(negedge clk_sys);
      reset = 1'b0;
      chk({7'h00, bus_width_bit}, 8'h01);
      chk({6'h00, two_line, font_5x11}, 8'h00);
      chk({7'h00, entry_increment}, 8'h01);
      ac_is(7'h00);
      chk({6'h00, data_oe, busy_flag}, 8'h00);
      test_end("reset");
      // function set: width, lines, font
      host.put(1'b0, 8'h34);
      chk({bus_width_bit, two_line, font_5x11}, 8'h05);
      host.put(1'b0, 8'h38);
      chk({bus_width_bit, two_line, font_5x11}, 8'h06);
      test_end("function");
      // display address, status read, line wraps in two-line mode
      host.put(1'b0, 8'ha7);
      ac_is(7'h27);
      chk({7'h00, glyph_selected}, 8'h00);
      host.xfer(1'b0, 1'b1, 8'h00, q);
      chk(q, 8'h27);
      host.put(1'b1, 8'ha5);
      ac_is(7'h40);
      host.put(1'b0, 8'he7);
      host.put(1'b1, 8'h11);
      ac_is(7'h00);
      test_end("two_line");
      // one-line wrap and reads
      host.put(1'b0, 8'h30);
      host.put(1'b0, 8'hcf);
      host.put(1'b1, 8'h22);
      ac_is(7'h00);
      host.put(1'b0, 8'ha8);
      host.put(1'b1, 8'h66);
      host.put(1'b0, 8'ha7);
      host.get(q);
      chk(q, 8'ha5);
      ac_is(7'h28);
      host.put(1'b1, 8'h77);
      ac_is(7'h29);
      host.get(q);
      chk(q, 8'h66);
      test_end("read");
      // cursor and display shifts
      host.put(1'b0, 8'h10);
      ac_is(7'h29);
      host.put(1'b0, 8'h10);
      host.get(q);
      chk(q, 8'h77);
      host.put(1'b0, 8'h14);
      ac_is(7'h2a);
      host.put(1'b0, 8'h18);
      chk({1'b0, display_offset}, 8'h01);
      ac_is(7'h2a);
      host.put(1'b0, 8'h1c);
      chk({1'b0, display_offset}, 8'h00);
      ac_is(7'h2a);
      test_end("shift");
      // entry direction
      host.put(1'b0, 8'h04);
      chk({7'h00, entry_increment}, 8'h00);
      host.put(1'b1, 8'h33);
      ac_is(7'h29);
      host.put(1'b0, 8'h06);
      host.put(1'b1, 8'h44);
      ac_is(7'h2a);
      test_end("entry");
      // glyph ram
      host.put(1'b0, 8'h7f);
      ac_is(7'h3f);
      chk({7'h00, glyph_selected}, 8'h01);
      host.put(1'b1, 8'h1f);
      ac_is(7'h00);
      host.put(1'b0, 8'h7f);
      host.get(q);
      chk(q, 8'h1f);
      test_end("glyph");
      // 4-bit bus: the mode changes when the instruction executes
      host.xfer(1'b0, 1'b0, 8'h28, q);
      host.four = 1'b1;
      host.wait_ready();
      chk({7'h00, bus_width_bit}, 8'h00);
      host.put(1'b0, 8'ha7);
      ac_is(7'h27);
      host.xfer(1'b0, 1'b1, 8'h00, q);
      chk(q, 8'h27);
      host.get(q);
      chk(q, 8'ha5);
      host.xfer(1'b0, 1'b0, 8'h30, q);
      host.four = 1'b0;
      host.wait_ready();
      chk({7'h00, bus_width_bit}, 8'h01);
      test_end("nibble");
      // shift on display write: increment entry moves the display left
      host.put(1'b0, 8'h07);
      chk({6'h00, entry_increment, shift_on_write_bit}, 8'h03);
      host.put(1'b0, 8'h80);
      host.put(1'b1, 8'h55);
      chk({1'b0, display_offset}, 8'h01);
      ac_is(7'h01);
      host.put(1'b0, 8'h06);
      chk({7'h00, shift_on_write_bit}, 8'h00);
      chk({6'h00, data_oe, busy_flag}, 8'h00);
      test_end("write_shift");
      test_done();
   end
endmodule

//--- test/cid_host_model.sv
// host processor model driving the parallel instruction and data bus
`timescale 1ns/10ps

module cid_host_model (
   input wire logic clk_sys,
   input wire logic [7:0] data_out,
   output logic bus_enable,
   output logic reg_select_line,
   output logic read_write,
   output logic [7:0] data_in
);
   logic four = 1'b0; // host side copy of the bus width
   logic [7:0] last_drive = 8'h00; // last value driven, inverted on release
   initial begin
      bus_enable = 1'b0;
      reg_select_line = 1'b0;
      read_write = 1'b0;
      data_in = 8'hff;
   end

   // one enable pulse; six cycles per phase keeps the five cycle holds
   task automatic cycle(input logic rs, input logic rw, input logic [7:0] d,
      output logic [7:0] q);
      @(negedge clk_sys);
      reg_select_line = rs;
      read_write = rw;
      if (!rw) last_drive = d;
      data_in = rw ? ~last_drive : d; // released lines do not keep a value
      repeat (6) @(negedge clk_sys);
      bus_enable = 1'b1;
      repeat (6) @(negedge clk_sys);
      q = data_out; // read data taken just before the falling enable
      bus_enable = 1'b0;
      repeat (6) @(negedge clk_sys);
      data_in = ~last_drive;
   endtask

   // one byte, split into two nibbles in 4-bit mode, upper first
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
      output logic [7:0] q);
      logic [7:0] hi;
      logic [7:0] lo;
      if (four) begin
         cycle(rs, rw, {d[7:4], 4'h0}, hi);
         cycle(rs, rw, {d[3:0], 4'h0}, lo);
         q = {hi[7:4], lo[7:4]};
      end else begin
         cycle(rs, rw, d, q);
      end
   endtask

   // poll status until busy reads low before the next operation
   task automatic wait_ready();
      logic [7:0] q;
      for (int i = 0; i < 200; i++) begin
         xfer(1'b0, 1'b1, 8'h00, q);
         if (q[7] === 1'b0) break;
      end
   endtask

   // the bench reads after an address set, a cursor shift or a data write, and never shifts
   // the display after a glyph read
   task automatic put(input logic rs, input logic [7:0] d);
      logic [7:0] q;
      xfer(rs, 1'b0, d, q);
      wait_ready();
   endtask

   task automatic get(output logic [7:0] q);
      xfer(1'b1, 1'b1, 8'h00, q);
      wait_ready();
   endtask
endmodule

//--- verilog/cid_decoder.sv
// host bus front end, command queue and instruction executor
`timescale 1ns/10ps

// simple synchronous fifo with valid/ready on both sides
module cid_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1]; // storage
   logic [AW-1:0] wr_ptr; // next slot to fill
   logic [AW-1:0] rd_ptr; // oldest slot
   logic [AW:0] count; // fill level
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];

   // pointer and level bookkeeping
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
         if (pop) rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // storage has no reset, contents are don't care when empty
   always_ff @(posedge clk_sys) begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule

// device side decoder: host pins in, mode and address state out
module cid_decoder (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic bus_enable,
   input wire logic reg_select_line,
   input wire logic read_write,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic busy_flag,
   output logic bus_width_bit,
   output logic two_line,
   output logic font_5x11,
   output logic glyph_selected,
   output logic [6:0] address_counter,
   output logic [6:0] display_offset,
   output logic entry_increment,
   output logic shift_on_write_bit
);
   typedef enum logic {ST_IDLE, ST_EXEC} cid_state_t;

   // pin synchroniser: {enable, rs, rw, data}
   logic [10:0] sync1, sync2, sync3;
   logic en_stable; // filtered enable level
   logic nib_phase; // 1 after the upper nibble
   logic [3:0] nib_hi; // held upper nibble
   logic pend_valid; // byte waiting for queue space
   cid_pkg::cid_cmd_t pend; // that byte
   cid_state_t state;
   logic [cid_pkg::CNT_W-1:0] cnt; // execution timer
   logic [7:0] out_reg; // ram read latch
   logic [7:0] dram [0:127]; // display text ram
   logic [7:0] gram [0:63]; // glyph pattern ram

   // edges count only once stages two and three agree
   wire agree = sync2[10] == sync3[10];
   wire en_rise = agree & sync3[10] & ~en_stable;
   wire en_fall = agree & ~sync3[10] & en_stable;
   wire s_rs = sync3[9];
   wire s_rw = sync3[8];
   wire [7:0] s_data = sync3[7:0];

   // byte assembly, upper nibble first in 4-bit mode
   wire complete = en_fall & (bus_width_bit | nib_phase);
   wire [7:0] asm_byte = bus_width_bit ? s_data
      : {nib_hi, s_data[7:4]};
   // status reads have no side effect and are not queued
   wire push_req = complete & (s_rs | ~s_rw);

   // queue between pins and executor
   wire q_in_ready;
   wire q_out_valid;
   cid_pkg::cid_cmd_t op;
   wire q_out_ready = state == ST_IDLE;
   cid_fifo #(.WIDTH(cid_pkg::CMD_W), .DEPTH(cid_pkg::FIFO_DEPTH)) u_q (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(pend_valid),
      .in_ready(q_in_ready),
      .in_data(pend),
      .out_valid(q_out_valid),
      .out_ready(q_out_ready),
      .out_data(op)
   );

   // instruction decode of the popped entry
   wire pop = q_out_valid & q_out_ready;
   wire [7:0] b = op.val;
   wire is_ins = pop & ~op.is_data;
   wire i_dd = is_ins & b[7];
   wire i_cg = is_ins & (b[7:6] == 2'b01);
   wire i_fn = is_ins & (b[7:5] == 3'b001);
   wire i_sh = is_ins & (b[7:4] == 4'b0001);
   wire i_em = is_ins & (b[7:2] == 6'b000001);
   wire d_wr = pop & op.is_data & ~op.is_read;
   wire d_rd = pop & op.is_data & op.is_read;
   wire cur_mv = i_sh & ~b[cid_pkg::B_SC];
   wire disp_mv = i_sh & b[cid_pkg::B_SC];
   wire step_up = op.is_data ? entry_increment : b[cid_pkg::B_RL];
   wire [6:0] step_ac = cid_pkg::cid_step(address_counter, step_up,
      two_line, glyph_selected);
   // address that feeds the read latch after this operation
   wire [6:0] load_addr = i_dd ? b[6:0]
      : i_cg ? {1'b0, b[5:0]}
      : disp_mv ? address_counter : step_ac;
   wire load_glyph = i_cg | (glyph_selected & ~i_dd);
   wire [7:0] ram_word = load_glyph ? gram[load_addr[5:0]]
      : dram[load_addr];
   wire do_load = i_dd | i_cg | d_rd
      | (i_sh & ~glyph_selected);
   // display moves on display shift instruction or on display ram write with shift set
   wire wr_shift = d_wr & shift_on_write_bit & ~glyph_selected;
   wire next_left = disp_mv ? ~b[cid_pkg::B_RL] : entry_increment;
   wire [6:0] next_offset = next_left ? display_offset + 7'h01
      : display_offset - 7'h01;
   // status read value: busy on the top line, counter below
   wire [7:0] rd_val = s_rs ? out_reg
      : {busy_flag, address_counter};
   wire [7:0] next_data_out = bus_width_bit ? rd_val
      : nib_phase ? {rd_val[3:0], 4'h0} : {rd_val[7:4], 4'h0};

   // busy while anything is queued or executing
   assign busy_flag = pend_valid | q_out_valid | (state == ST_EXEC);

   // three stage pin synchroniser and filtered enable
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync1 <= 11'h000;
         sync2 <= 11'h000;
         sync3 <= 11'h000;
         en_stable <= 1'b0;
      end else begin
         sync1 <= {bus_enable, reg_select_line, read_write, data_in};
         sync2 <= sync1;
         sync3 <= sync2;
         if (agree) en_stable <= sync3[10];
      end
   end

   // host side: nibble phase, read drive, pending byte
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         nib_phase <= 1'b0;
         nib_hi <= 4'h0;
         data_out <= 8'h00;
         data_oe <= 1'b0;
         pend_valid <= 1'b0;
         pend <= '0;
      end else begin
         // drive lines from enable rise to fall on reads
         if (en_rise & s_rw) begin
            data_out <= next_data_out;
            data_oe <= 1'b1;
         end else if (en_fall) begin
            data_oe <= 1'b0;
         end
         // two nibble transfers form one byte
         if (en_fall & ~bus_width_bit) begin
            nib_phase <= ~nib_phase;
            nib_hi <= s_data[7:4];
         end else if (bus_width_bit) begin
            nib_phase <= 1'b0;
         end
         // a new byte wins over the queue taking the old one
         if (push_req) begin
            pend_valid <= 1'b1;
            pend <= '{is_data: s_rs, is_read: s_rw, val: asm_byte};
         end else if (q_in_ready) begin
            pend_valid <= 1'b0;
         end
      end
   end

   // executor timing: every queued entry holds busy a fixed time
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         cnt <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (pop) begin
                  state <= ST_EXEC;
                  cnt <= (op.is_data ? cid_pkg::DATA_CYC
                     : cid_pkg::INSTR_CYC) - 1'b1;
               end
            end
            ST_EXEC: begin
               if (cnt == '0) state <= ST_IDLE;
               else cnt <= cnt - 1'b1;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // mode bits, address counter, shift offset and read latch
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bus_width_bit <= 1'b1;
         two_line <= 1'b0;
         font_5x11 <= 1'b0;
         glyph_selected <= 1'b0;
         address_counter <= 7'h00;
         display_offset <= 7'h00;
         entry_increment <= 1'b1;
         shift_on_write_bit <= 1'b0;
         out_reg <= 8'h00;
      end else begin
         if (i_fn) begin
            bus_width_bit <= b[cid_pkg::B_DL];
            two_line <= b[cid_pkg::B_N];
            font_5x11 <= b[cid_pkg::B_F];
         end
         if (i_em) begin
            entry_increment <= b[cid_pkg::B_ID];
            shift_on_write_bit <= b[cid_pkg::B_SH];
         end
         if (i_cg) begin
            address_counter <= {1'b0, b[5:0]};
            glyph_selected <= 1'b1;
         end else if (i_dd) begin
            address_counter <= b[6:0];
            glyph_selected <= 1'b0;
         end else if (cur_mv | d_wr | d_rd) begin
            // line wraps follow the display line mode
            address_counter <= step_ac;
         end
         // counter untouched by display shift
         if (disp_mv | wr_shift) display_offset <= next_offset;
         // writes do not refresh the latch
         if (do_load) out_reg <= ram_word;
      end
   end

   // ram write port into the selected ram
   always_ff @(posedge clk_sys) begin
      if (d_wr & glyph_selected) gram[address_counter[5:0]] <= b;
      if (d_wr & ~glyph_selected) dram[address_counter] <= b;
   end

   // checks on executor and host side behaviour
   sequence pop_cur(logic rl);
      cur_mv && b[cid_pkg::B_RL] == rl && !glyph_selected;
   endsequence
   sequence status_rise;
      en_rise && s_rw && !s_rs && bus_width_bit;
   endsequence

   AST_CUR_LEFT: assert property (@(posedge clk_sys) disable iff (reset)
      pop_cur(1'b0) ##0 (address_counter > 7'h00 && address_counter < 7'h27)
      |=> address_counter == $past(address_counter) - 7'h01)
      else $error("cursor left did not decrement");
   AST_CUR_RIGHT: assert property (@(posedge clk_sys) disable iff (reset)
      pop_cur(1'b1) ##0 (address_counter < 7'h27)
      |=> address_counter == $past(address_counter) + 7'h01)
      else $error("cursor right did not increment");
   AST_DISP_SHIFT: assert property (@(posedge clk_sys) disable iff (reset)
      disp_mv |=> $stable(address_counter)
      && display_offset != $past(display_offset))
      else $error("display shift moved counter or not display");
   AST_WIDTH: assert property (@(posedge clk_sys) disable iff (reset)
      i_fn |=> bus_width_bit == $past(b[cid_pkg::B_DL])
      && state == ST_EXEC)
      else $error("width bit not taken");
   AST_DD_ADDR: assert property (@(posedge clk_sys) disable iff (reset)
      i_dd |=> address_counter == $past(b[6:0]) && !glyph_selected)
      else $error("display address not loaded");
   AST_CG_ADDR: assert property (@(posedge clk_sys) disable iff (reset)
      i_cg |=> address_counter == {1'b0, $past(b[5:0])} && glyph_selected)
      else $error("glyph address not loaded");
   AST_WRAP_ONE: assert property (@(posedge clk_sys) disable iff (reset)
      d_wr && !glyph_selected && !two_line && entry_increment
      && address_counter == 7'h4f |=> address_counter == 7'h00)
      else $error("one line wrap wrong");
   AST_WRAP_TWO: assert property (@(posedge clk_sys) disable iff (reset)
      d_wr && !glyph_selected && two_line && entry_increment
      && address_counter == 7'h27 |=> address_counter == 7'h40)
      else $error("two line wrap wrong");
   AST_STATUS: assert property (@(posedge clk_sys) disable iff (reset)
      status_rise |=> data_oe && data_out == {$past(busy_flag),
      $past(address_counter)})
      else $error("status read value wrong");
   AST_WRITE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      d_wr |=> $stable(out_reg) ##1 $stable(out_reg))
      else $error("write refreshed read latch");
   AST_NIBBLE: assert property (@(posedge clk_sys) disable iff (reset)
      en_fall && !bus_width_bit && !nib_phase |-> !complete ##1 nib_phase)
      else $error("upper nibble completed a byte");
   AST_BUSY_TIME: assert property (@(posedge clk_sys) disable iff (reset)
      d_wr |=> busy_flag [*8])
      else $error("busy dropped early after write");
endmodule

//--- verilog/cid_pkg.sv
// shared constants, types and helpers for the lcd instruction decoder
package cid_pkg;
   // host bus entry passed through the command queue
   typedef struct packed {
      logic is_data; // register select was high
      logic is_read; // data read: step and refetch only
      logic [7:0] val; // assembled byte
   } cid_cmd_t;

   localparam int CMD_W = 10;
   localparam int FIFO_DEPTH = 8;
   // timing: instruction and ram access execution times
   localparam int CLK_NS = 100;
   localparam int EXEC_INSTR_NS = 39000;
   localparam int EXEC_DATA_NS = 43000;
   localparam int CNT_W = 9;
   localparam logic [CNT_W-1:0] INSTR_CYC =
      CNT_W'((EXEC_INSTR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] DATA_CYC =
      CNT_W'((EXEC_DATA_NS + CLK_NS - 1) / CLK_NS);
   // display ram address map
   localparam logic [6:0] DD_START = 7'h00;
   localparam logic [6:0] L1_END = 7'h4f;
   localparam logic [6:0] L1_LAST = 7'h27;
   localparam logic [6:0] L2_START = 7'h40;
   localparam logic [6:0] L2_END = 7'h67;
   // instruction field positions
   localparam int B_SC = 3;
   localparam int B_RL = 2;
   localparam int B_DL = 4;
   localparam int B_N = 3;
   localparam int B_F = 2;
   localparam int B_ID = 1;
   localparam int B_SH = 0;

   // address counter step with line wrap
   function automatic logic [6:0] cid_step(input logic [6:0] a,
      input logic up, input logic two, input logic glyph);
      logic [6:0] r;
      begin
         r = up ? a + 7'h01 : a - 7'h01;
         if (glyph) begin
            r = {1'b0, r[5:0]};
         end else if (!two) begin
            if (up && a == L1_END) r = DD_START;
            else if (!up && a == DD_START) r = L1_END;
         end else begin
            if (up && a == L1_LAST) r = L2_START;
            else if (up && a == L2_END) r = DD_START;
            else if (!up && a == L2_START) r = L1_LAST;
            else if (!up && a == DD_START) r = L2_END;
         end
         cid_step = r;
      end
   endfunction
endpackage
